// File: design/dp_sync.sv
// Two-stage synchroniser for a bundle of bits entering a clock domain.
`timescale 1ns/1ns
`default_nettype none
module dp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Reset loads the idle level so edge detectors behind the chain stay quiet.
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else if (en)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// File: design/dp_wiper_ctrl.sv
// Wiper control of a 1024-position potentiometer: serial port, step port and stored copy.
//
// Behaviour
// - Interface select high runs the serial port, low runs the step port.
// - Wiper code is ten bits, positions 0 to 1023.
// - Serial and step inputs act only while chip select is low.
// - In step mode each falling step edge moves the wiper one position; steps stop at 0 and 1023.
// - Direction high at the step edge increments, low decrements.
// - Serial mode shifts data in on every serial clock rising edge.
// - Serial port is receive-only; nothing can be read back.
// - Write-wiper uses code 00 in a frame of exactly 24 clocks.
// - Copy commands accept 8 or 24 clocks; last 16 bits are ignored.
// - MSB first; command on edges 3-4, data on 9-18, edges 1-2 and 5-8 zero.
// - Code 00 writes wiper, 10 saves wiper, 11 recalls stored copy.
// - A command acts only at the chip select rise after the frame.
// - Write-wiper data bits become the new wiper code.
// - Write-wiper leaves the stored copy unchanged.
// - After power-up the wiper loads the stored copy.
// - Step mode: chip select rising with step high stores the wiper.
// - Step mode: chip select rising with step low deselects without storing.
// - A store keeps the device busy for up to 12 ms.
// - The stored copy starts at midscale.
`timescale 1ns/1ns
`default_nettype none
module dp_wiper_ctrl
  import dp_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYCLES_DFLT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic cs_n,
  input wire logic interface_select,
  output logic [WIPER_W-1:0] wiper_code,
  output logic [WIPER_W-1:0] nonvolatile_copy,
  output logic store_busy,
  output logic frame_drop
);

  // ---------------- Link domain, clocked by the serial clock pin ----------------

  logic link_rst;
  logic [FRAME_W-1:0] shift_q;
  logic [CNT_W-1:0] lcnt_q;
  logic [CNT_W-1:0] lcnt_d;
  logic [CNT_W-1:0] lgray_q;

  // The serial clock may stop between frames, so reset needs it toggling.
  dp_sync #(.WIDTH(1)) u_link_rst (
    .clk(serial_clk),
    .rst(1'b0),
    .en(1'b1),
    .d(rst),
    .q(link_rst)
  );

  assign lcnt_d = lcnt_q + 8'h01;

  // Chip select is timed to the serial clock by the host, so it is read directly here.
  // The bit count runs free; the other domain takes its difference across a frame.
  always_ff @(posedge serial_clk)
  begin
    if (link_rst)
    begin
      shift_q <= '0;
      lcnt_q <= '0;
      lgray_q <= '0;
    end
    else if (!cs_n)
    begin
      shift_q <= {shift_q[FRAME_W-2:0], serial_data};
      lcnt_q <= lcnt_d;
      lgray_q <= lcnt_d ^ (lcnt_d >> 1);
    end
  end

  AST_SHIFT_ON_CLOCK: assert property (@(posedge serial_clk) disable iff (link_rst)
    !cs_n |=> (shift_q[0] == $past(serial_data)) && (lcnt_q == $past(lcnt_q) + 8'h01))
    else $error("Serial bit not shifted on clock rise.");

  // ---------------- System domain ----------------

  dp_pins_type pins_raw;
  dp_pins_type pins_s;
  dp_frame_type frame_raw;
  dp_frame_type frame_s;

  assign pins_raw = '{sel: interface_select, cs_n: cs_n, step: serial_clk, dir: serial_data};
  assign frame_raw = '{bits: shift_q, gray: lgray_q};

  dp_sync #(.WIDTH($bits(dp_pins_type)), .RST_VAL(PINS_IDLE)) u_pin_sync (
    .clk(sys_clk),
    .rst(rst),
    .en(ce),
    .d(pins_raw),
    .q(pins_s)
  );

  // The frame word is quasi-static when it is read: the serial clock has stopped
  // before chip select rises, and the read waits one cycle past the synced edge.
  dp_sync #(.WIDTH($bits(dp_frame_type))) u_frame_sync (
    .clk(sys_clk),
    .rst(rst),
    .en(ce),
    .d(frame_raw),
    .q(frame_s)
  );

  logic cs_prev_q;
  logic step_prev_q;
  logic cs_rise_q;
  logic step_at_rise_q;
  logic [CNT_W-1:0] start_cnt_q;
  dp_state_type state_q;
  dp_state_type state_d;
  logic [WIPER_W-1:0] wiper_q;
  logic [WIPER_W-1:0] wiper_d;
  logic [WIPER_W-1:0] nv_q;
  logic [WIPER_W-1:0] nv_d;
  logic [BUSY_W-1:0] busy_cnt_q;
  logic [BUSY_W-1:0] busy_cnt_d;
  logic busy_q;
  logic drop_q;

  // Edge detection on synchronised pins.
  wire cs_rise = pins_s.cs_n & ~cs_prev_q;
  wire cs_fall = ~pins_s.cs_n & cs_prev_q;
  wire step_fall = ~pins_s.step & step_prev_q;
  wire serial_mode = pins_s.sel;

  // Frame decode, performed one cycle after the chip select rise.
  wire [CNT_W-1:0] end_cnt = dp_gray_to_bin(frame_s.gray);
  wire [CNT_W-1:0] frame_len = end_cnt - start_cnt_q;
  wire len_long = frame_len == LEN_LONG;
  wire len_short = frame_len == LEN_SHORT;
  wire [FRAME_W-1:0] fb = frame_s.bits;
  wire [1:0] cmd_long = fb[LONG_CMD_HI:LONG_CMD_LO];
  wire [1:0] cmd_short = fb[SHORT_CMD_HI:SHORT_CMD_LO];
  wire [1:0] cmd = len_long ? cmd_long : cmd_short;
  wire zeros_long = ~|(fb & LONG_ZERO_MASK);
  wire zeros_short = ~|(fb & SHORT_ZERO_MASK);
  wire zeros_ok = len_long ? zeros_long : zeros_short;
  wire [WIPER_W-1:0] frame_data = fb[LONG_DATA_HI:LONG_DATA_LO];
  wire serial_end = cs_rise_q & serial_mode;
  wire len_ok = len_long | len_short;
  wire do_write = serial_end & len_long & zeros_ok & (cmd == CMD_WRITE);
  wire do_save = serial_end & len_ok & zeros_ok & (cmd == CMD_SAVE);
  wire do_recall = serial_end & len_ok & zeros_ok & (cmd == CMD_RECALL);
  wire do_drop = serial_end & ~(do_write | do_save | do_recall);

  // Step port decode.
  wire step_move = ~serial_mode & ~pins_s.cs_n & step_fall;
  wire step_end = cs_rise_q & ~serial_mode;
  wire step_store = step_end & step_at_rise_q;
  wire at_max = wiper_q == WIPER_MAX;
  wire at_min = wiper_q == WIPER_MIN;
  wire [WIPER_W-1:0] wiper_up = at_max ? WIPER_MAX : wiper_q + WIPER_STEP;
  wire [WIPER_W-1:0] wiper_dn = at_min ? WIPER_MIN : wiper_q - WIPER_STEP;
  wire [WIPER_W-1:0] wiper_step = pins_s.dir ? wiper_up : wiper_dn;

  // A second store while one is still in progress is ignored.
  wire nv_load = (do_save | step_store) & (state_q == ST_IDLE);
  wire busy_done = busy_cnt_q == BUSY_ZERO;

  always_comb
  begin
    state_d = state_q;
    wiper_d = wiper_q;
    nv_d = nv_q;
    busy_cnt_d = busy_cnt_q;
    case (state_q)
      ST_RECALL:
      begin
        wiper_d = nv_q;
        state_d = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (nv_load)
        begin
          nv_d = wiper_q;
          busy_cnt_d = BUSY_W'(STORE_CYCLES - 1);
          state_d = ST_STORE;
        end
      end
      ST_STORE:
      begin
        if (busy_done)
        begin
          state_d = ST_IDLE;
        end
        else
        begin
          busy_cnt_d = busy_cnt_q - 21'h000001;
        end
      end
      default:
      begin
        state_d = ST_RECALL;
      end
    endcase
    if (state_q != ST_RECALL)
    begin
      if (do_write)
      begin
        wiper_d = frame_data;
      end
      else if (do_recall)
      begin
        wiper_d = nv_q;
      end
      else if (step_move)
      begin
        wiper_d = wiper_step;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cs_prev_q <= 1'b1;
      step_prev_q <= 1'b0;
      cs_rise_q <= 1'b0;
      step_at_rise_q <= 1'b0;
      start_cnt_q <= '0;
    end
    else if (ce)
    begin
      cs_prev_q <= pins_s.cs_n;
      step_prev_q <= pins_s.step;
      cs_rise_q <= cs_rise;
      if (cs_rise)
      begin
        step_at_rise_q <= pins_s.step;
      end
      if (cs_fall)
      begin
        start_cnt_q <= end_cnt;
      end
    end
  end

  // The stored copy models the nonvolatile cell; reset stands in for its factory state.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= ST_RECALL;
      wiper_q <= WIPER_MID;
      nv_q <= WIPER_MID;
      busy_cnt_q <= BUSY_ZERO;
      busy_q <= 1'b0;
      drop_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      wiper_q <= wiper_d;
      nv_q <= nv_d;
      busy_cnt_q <= busy_cnt_d;
      busy_q <= state_d == ST_STORE;
      drop_q <= do_drop;
    end
  end

  // There is deliberately no path from the wiper or stored copy back to the serial data pin.
  assign wiper_code = wiper_q;
  assign nonvolatile_copy = nv_q;
  assign store_busy = busy_q;
  assign frame_drop = drop_q;

  // ---------------- Checks ----------------

  AST_RECALL_AT_START: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_RECALL) && ce |=> (wiper_q == $past(nv_q)) && (state_q == ST_IDLE))
    else $error("Wiper did not load the stored copy after reset.");

  AST_FACTORY_MIDSCALE: assert property (@(posedge sys_clk)
    $fell(rst) |-> (nv_q == WIPER_MID))
    else $error("Stored copy not at midscale after reset.");

  AST_STEP_UP: assert property (@(posedge sys_clk) disable iff (rst)
    ce && step_move && pins_s.dir && !at_max && state_q != ST_RECALL
    |=> wiper_q == $past(wiper_q) + WIPER_STEP)
    else $error("Step with direction high did not increment.");

  AST_STEP_DOWN: assert property (@(posedge sys_clk) disable iff (rst)
    ce && step_move && !pins_s.dir && !at_min && state_q != ST_RECALL
    |=> wiper_q == $past(wiper_q) - WIPER_STEP)
    else $error("Step with direction low did not decrement.");

  AST_STEP_SATURATE: assert property (@(posedge sys_clk) disable iff (rst)
    ce && step_move && ((pins_s.dir && at_max) || (!pins_s.dir && at_min))
    |=> $stable(wiper_q))
    else $error("Step counter wrapped past an end.");

  AST_WRITE_WIPER: assert property (@(posedge sys_clk) disable iff (rst)
    ce && do_write && state_q != ST_RECALL
    |=> (wiper_q == $past(frame_data)) && (nv_q == $past(nv_q)))
    else $error("Write command did not set the wiper alone.");

  AST_RECALL_CMD: assert property (@(posedge sys_clk) disable iff (rst)
    ce && do_recall && state_q != ST_RECALL |=> wiper_q == $past(nv_q))
    else $error("Recall command did not restore the stored copy.");

  AST_DROP_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
    ce && do_drop && state_q == ST_IDLE
    |=> $stable(wiper_q) && $stable(nv_q) && frame_drop)
    else $error("Discarded frame changed state.");

  AST_QUIET_WITHOUT_CAUSE: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !step_move && !do_write && !do_recall && state_q != ST_RECALL
    |=> $stable(wiper_q))
    else $error("Wiper moved with no command or step.");

  AST_STORE_START: assert property (@(posedge sys_clk) disable iff (rst)
    ce && step_store && state_q == ST_IDLE
    |=> (nv_q == $past(wiper_q)) && store_busy)
    else $error("Store at deselect did not capture the wiper.");

  AST_SKIP_STORE: assert property (@(posedge sys_clk) disable iff (rst)
    ce && step_end && !step_at_rise_q |=> $stable(nv_q) && !($rose(store_busy)))
    else $error("Deselect with step low stored the wiper.");

  AST_BUSY_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
    store_busy && !busy_done |=> store_busy)
    else $error("Store busy ended before its time.");

endmodule
`default_nettype wire

// File: pkg/dp_pkg.sv
// Constants, carrier types and helpers shared by the wiper control design.
package dp_pkg;

  localparam int WIPER_W = 10;
  localparam logic [WIPER_W-1:0] WIPER_MIN = 10'h000;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 10'h3FF;
  localparam logic [WIPER_W-1:0] WIPER_MID = 10'h200;
  localparam logic [WIPER_W-1:0] WIPER_STEP = 10'h001;

  localparam int FRAME_W = 24;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] LEN_SHORT = 8'h08;
  localparam logic [CNT_W-1:0] LEN_LONG = 8'h18;

  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_SAVE = 2'h2;
  localparam logic [1:0] CMD_RECALL = 2'h3;

  // Bit positions inside the shift register, newest bit at index 0.
  localparam int LONG_CMD_HI = 21;
  localparam int LONG_CMD_LO = 20;
  localparam int LONG_DATA_HI = 15;
  localparam int LONG_DATA_LO = 6;
  localparam int SHORT_CMD_HI = 5;
  localparam int SHORT_CMD_LO = 4;
  localparam logic [FRAME_W-1:0] LONG_ZERO_MASK = 24'hCF0000;
  localparam logic [FRAME_W-1:0] SHORT_ZERO_MASK = 24'h0000CF;

  localparam int STORE_TIME_MS = 12;
  localparam int SYS_CLK_HZ = 100000000;
  localparam int STORE_CYCLES_DFLT = STORE_TIME_MS * (SYS_CLK_HZ / 1000);
  localparam int BUSY_W = 21;
  localparam logic [BUSY_W-1:0] BUSY_ZERO = 21'h000000;

  typedef struct packed {
    logic sel;
    logic cs_n;
    logic step;
    logic dir;
  } dp_pins_type;

  // Reset image of the synchronised pins: chip select high, so no false edge follows reset.
  localparam logic [3:0] PINS_IDLE = 4'h4;

  typedef struct packed {
    logic [FRAME_W-1:0] bits;
    logic [CNT_W-1:0] gray;
  } dp_frame_type;

  typedef enum logic [2:0] {
    ST_RECALL = 3'b001,
    ST_IDLE = 3'b010,
    ST_STORE = 3'b100
  } dp_state_type;

  function automatic logic [CNT_W-1:0] dp_gray_to_bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = g;
    for (int i = CNT_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// File: tb/dp_host_model.sv
// Behavioural host that drives the serial and step pins of the wiper control.
`timescale 1ns/1ns
`default_nettype none
module dp_host_model (
  output var logic serial_clk,
  output var logic serial_data,
  output var logic cs_n,
  output var logic interface_select
);
  // Half of the 48 ns link clock; the clock only toggles when a task drives it.
  localparam int HALF = 24;
  initial
  begin
    serial_clk = 1'b0;
    serial_data = 1'b1;
    cs_n = 1'b1;
    interface_select = 1'b1;
  end
  task automatic clocks(input int n);
    repeat (n)
    begin
      #HALF serial_clk = 1'b1;
      #HALF serial_clk = 1'b0;
    end
  endtask
  // Sends the top len bits and keeps chip select low, so a check can look before the latch.
  task automatic shift(input logic [23:0] bits, input int len);
    interface_select = 1'b1;
    #200 cs_n = 1'b0;
    #60;
    for (int i = 0; i < len; i++)
    begin
      serial_data = bits[23-i];
      clocks(1);
    end
    serial_data = ~serial_data;
  endtask
  task automatic release_cs();
    #60 cs_n = 1'b1;
    #300;
  endtask
  task automatic steps(input int n, input logic up, input logic store);
    interface_select = 1'b0;
    serial_clk = 1'b1;
    #200 cs_n = 1'b0;
    serial_data = up;
    for (int i = 0; i < n; i++)
    begin
      #60 serial_clk = 1'b0;
      // Without a store the last falling edge is the last step and the clock stays low.
      if (i < n - 1 || store)
        #60 serial_clk = 1'b1;
    end
    #60 cs_n = 1'b1;
    serial_data = ~up;
    // A falling step edge while deselected must not move the wiper.
    #300 serial_clk = 1'b1;
    #100 serial_clk = 1'b0;
    #300;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the wiper control driven by the host model.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dp_pkg::*;
  localparam int STORE_N = 20;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  wire logic serial_clk, serial_data, cs_n, interface_select;
  logic [WIPER_W-1:0] wiper_code;
  logic [WIPER_W-1:0] nonvolatile_copy;
  logic store_busy;
  logic frame_drop;
  int err_total = 0;
  int total_checks = 0;
  int drops = 0;
  int busy_len = 0;
  always #5 sys_clk = ~sys_clk;
  dp_host_model i_host (
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .cs_n(cs_n),
    .interface_select(interface_select)
  );
  dp_wiper_ctrl #(.STORE_CYCLES(STORE_N)) i_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .cs_n(cs_n),
    .interface_select(interface_select),
    .wiper_code(wiper_code),
    .nonvolatile_copy(nonvolatile_copy),
    .store_busy(store_busy),
    .frame_drop(frame_drop)
  );
  always @(posedge sys_clk)
  begin
    if (frame_drop === 1'b1)
      drops++;
    if (store_busy === 1'b1)
      busy_len++;
  end
  task automatic chk(input logic [WIPER_W-1:0] got, input logic [WIPER_W-1:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait; the host issues nothing while a store is running.
  task automatic settle();
    repeat (200)
    begin
      @(posedge sys_clk);
      if (store_busy !== 1'b1)
        break;
    end
  endtask
  task automatic wr(input logic [WIPER_W-1:0] v);
    i_host.shift({8'h00, v, 6'h3F}, 24);
    i_host.release_cs();
  endtask
  task automatic t_power();
    chk(wiper_code, WIPER_MID, "wiper after power-up");
    chk(nonvolatile_copy, WIPER_MID, "stored copy after power-up");
    chk(10'(store_busy), 10'h000, "busy after power-up");
    $display("test power done");
  endtask
  task automatic t_write();
    logic [WIPER_W-1:0] vals [3];
    logic [WIPER_W-1:0] prev;
    vals = '{10'h155, WIPER_MIN, WIPER_MAX};
    prev = WIPER_MID;
    foreach (vals[i])
    begin
      i_host.shift({8'h00, vals[i], 6'h2A}, 24);
      #300;
      chk(wiper_code, prev, "wiper moved before deselect");
      i_host.release_cs();
      chk(wiper_code, vals[i], "written wiper");
      chk(nonvolatile_copy, WIPER_MID, "stored copy after write");
      prev = vals[i];
    end
    $display("test write done");
  endtask
  task automatic t_copy();
    wr(10'h0AB);
    busy_len = 0;
    i_host.shift(24'h200000, 8);
    i_host.release_cs();
    chk(nonvolatile_copy, 10'h0AB, "short save");
    settle();
    chk(10'(busy_len), 10'(STORE_N), "busy length");
    wr(10'h3C0);
    i_host.shift(24'h30FFFF, 24);
    i_host.release_cs();
    chk(wiper_code, 10'h0AB, "long recall");
    wr(10'h2D2);
    i_host.shift(24'h20FFFF, 24);
    i_host.release_cs();
    chk(nonvolatile_copy, 10'h2D2, "long save");
    settle();
    $display("test copy done");
  endtask
  task automatic t_drop();
    logic [23:0] bad [4];
    int lens [4];
    int d0;
    bad = '{24'h100000, 24'h000000, 24'h200000, 24'h800000};
    lens = '{24, 8, 16, 24};
    wr(10'h111);
    foreach (bad[i])
    begin
      d0 = drops;
      i_host.shift(bad[i], lens[i]);
      i_host.release_cs();
      chk(10'(drops - d0), 10'h001, "drop pulse");
      chk(wiper_code, 10'h111, "wiper after bad frame");
      chk(nonvolatile_copy, 10'h2D2, "stored copy after bad frame");
    end
    $display("test drop done");
  endtask
  task automatic t_step();
    wr(10'h3FE);
    i_host.steps(3, 1'b1, 1'b0);
    chk(wiper_code, WIPER_MAX, "step up saturates");
    chk(nonvolatile_copy, 10'h2D2, "no store with step low");
    i_host.steps(2, 1'b0, 1'b1);
    chk(wiper_code, 10'h3FD, "step down");
    chk(nonvolatile_copy, 10'h3FD, "store with step high");
    settle();
    wr(10'h001);
    i_host.steps(3, 1'b0, 1'b0);
    chk(wiper_code, WIPER_MIN, "step down saturates");
    $display("test step done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    // The link side resets through a synchroniser, so it needs clocks during reset.
    fork
      i_host.clocks(4);
      repeat (10) @(posedge sys_clk);
    join
    @(posedge sys_clk);
    #1 rst = 1'b0;
    // The link reset only clears on serial clocks, so a few run while deselected.
    i_host.clocks(3);
    repeat (5) @(posedge sys_clk);
    t_power();
    t_write();
    t_copy();
    t_drop();
    t_step();
    end_sim();
  end
  initial
  begin
    #300000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
